// file: hw/vic_pkg.sv
// What this block does
// - Rank peripheral requests outside the core; present only the winning one.
// - Sources share vectors; source and vector counts are parameters.
// - Single-vector mode uses one entry address; multi-vector mode one per vector.
// - Five external pins, each with a selectable edge that sets its flag.
// - Three-bit priority per vector at bits 4:2 of its slot.
// - Two-bit subpriority orders equal priorities, bits 1:0 of its slot.
// - Each priority register holds four vector slots, eight bits apart.
// - Request n uses flag and enable bit n%32 of word n/32.
// - Writing a flag from software raises the request like the hardware event.
// - Software sets the vector table base; entry addresses start there.
// - Software sets the entry spacing; vector number times spacing is added.
// - No shadow register set is selected for any priority level.
// - External and timer requests use their fixed request numbers and vectors.
// - Capture error and capture request share a vector, error numbered lower.
// - Compare units use requests 7,12,17,22,27 on vectors 6,10,14,18,22.
// - Converter on 28/23; clock monitor, calendar, flash on 29-31/24-26.
// - Comparators use requests 32 and 33, vectors 27 and 28.
// - Bus device request 34 on vector 29, fields in eighth priority register.
// - Serial, async serial and two-wire triples share vectors 30, 31, 32.
// - Persistent sources set while requesting; external pins on their selected edge; others set on a rising edge.
package vic_pkg;

  localparam int SRC_MAX      = 44;
  localparam int VEC_MAX      = 33;
  localparam int NUM_EXT      = 5;
  localparam int NUM_PRIO_REG = 9;
  localparam int ADDR_W       = 8;
  localparam int VSPACE_W     = 16;
  localparam int SLOT_W       = 8;
  localparam int PRIO_LSB     = 2;
  localparam int SUB_LSB      = 0;
  localparam int CTRL_MVEC    = 0;
  localparam int CTRL_POL_LSB = 8;

  localparam logic [ADDR_W-1:0] OFF_FLAG_LO   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_FLAG_HI   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_EN_LO     = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_EN_HI     = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_PRIO_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_CTRL      = 8'h40;
  localparam logic [ADDR_W-1:0] OFF_VBASE     = 8'h44;
  localparam logic [ADDR_W-1:0] OFF_VSPACE    = 8'h48;
  localparam logic [ADDR_W-1:0] OFF_STATUS    = 8'h4C;

  localparam logic [31:0]         PRIO_MASK  = 32'h1F1F1F1F;
  localparam logic [31:0]         RST_WORD   = 32'h00000000;
  localparam logic [VSPACE_W-1:0] RST_VSPACE = 16'h0020;
  localparam logic [NUM_EXT-1:0]  RST_POL    = 5'h1F;

  localparam logic [SRC_MAX-1:0] PERSIST_MASK = 44'hFFC16318C60;
  localparam logic [SRC_MAX-1:0] EXT_MASK     = 44'h00000842108;
  localparam int EXT_SRC [NUM_EXT] = '{3, 8, 13, 18, 23};

  localparam logic [5:0] VEC_OF_SRC [SRC_MAX] = '{
    6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h05, 6'h06,
    6'h07, 6'h08, 6'h09, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D,
    6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h11, 6'h11, 6'h12, 6'h13,
    6'h14, 6'h15, 6'h15, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1A,
    6'h1B, 6'h1C, 6'h1D, 6'h1E, 6'h1E, 6'h1E, 6'h1F, 6'h1F,
    6'h1F, 6'h20, 6'h20, 6'h20};

  typedef struct packed {
    logic        valid;
    logic [5:0]  vector;
    logic [2:0]  prio;
    logic [1:0]  sub;
    logic [31:0] addr;
  } vic_irq_t;

endpackage

// file: hw/vic_top.sv
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/100ps
module vic_top #(
  parameter int NUM_SRC = vic_pkg::SRC_MAX,
  parameter int NUM_VEC = vic_pkg::VEC_MAX
) (
  input  wire logic                      mclk_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      ce_i,
  input  wire logic [vic_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [31:0]               wdata_i,
  input  wire logic                      wr_i,
  input  wire logic                      rd_i,
  output logic      [31:0]               rdata_o,
  input  wire logic [NUM_SRC-1:0]        src_req_i,
  input  wire logic [vic_pkg::NUM_EXT-1:0] ext_pin_i,
  output vic_pkg::vic_irq_t              irq_o
);
  import vic_pkg::*;

  if (NUM_SRC < 1 || NUM_SRC > SRC_MAX) begin : g_bad_src
    $error("NUM_SRC out of range");
  end
  if (NUM_VEC < 1 || NUM_VEC > NUM_PRIO_REG * 4) begin : g_bad_vec
    $error("NUM_VEC out of range");
  end

  logic [63:0]               flags;
  logic [63:0]               enables;
  logic [31:0]               prio_reg [NUM_PRIO_REG];
  logic                      multi_vec;
  logic [NUM_EXT-1:0]        ext_pol;
  logic [31:0]               vbase;
  logic [VSPACE_W-1:0]       vspace;

  logic [NUM_EXT-1:0]        ext_meta;
  logic [NUM_EXT-1:0]        ext_sync;
  logic [NUM_EXT-1:0]        ext_last;
  logic [NUM_EXT-1:0]        ext_evt;
  logic [2:0]                ext_warm;
  logic [NUM_SRC-1:0]        req_last;
  logic [63:0]               hw_set;
  logic [63:0]               impl_mask;

  logic [63:0]               next_flags;
  logic [63:0]               next_enables;
  logic [NUM_VEC-1:0]        vec_pend;
  logic [2:0]                vec_prio [NUM_VEC];
  logic [1:0]                vec_sub  [NUM_VEC];

  logic                      win_found;
  logic [5:0]                win_vec;
  logic [2:0]                win_prio;
  logic [1:0]                win_sub;
  logic [31:0]               next_addr;
  logic [31:0]               next_rdata;

  logic                      wr_flag_lo;
  logic                      wr_flag_hi;
  logic                      wr_en_lo;
  logic                      wr_en_hi;

  assign wr_flag_lo = wr_i && (addr_i == OFF_FLAG_LO);
  assign wr_flag_hi = wr_i && (addr_i == OFF_FLAG_HI);
  assign wr_en_lo   = wr_i && (addr_i == OFF_EN_LO);
  assign wr_en_hi   = wr_i && (addr_i == OFF_EN_HI);

  // Bits above the implemented sources never hold a flag or enable.
  always_comb begin
    impl_mask = '0;
    impl_mask[NUM_SRC-1:0] = '1;
  end

  // Pins are asynchronous; the first stage feeds only the second.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ext_meta <= '0;
      ext_sync <= '0;
      ext_last <= '0;
      ext_warm <= '0;
    end else if (ce_i) begin
      ext_meta <= ext_pin_i;
      ext_sync <= ext_meta;
      ext_last <= ext_sync;
      ext_warm <= {ext_warm[1:0], 1'b1};
    end
  end

  // A set polarity bit picks the rising edge, a clear one the falling.
  // Edges are ignored until the chain has refilled after reset, so a pin
  // that idles high raises no false event.
  always_comb begin
    for (int e = 0; e < NUM_EXT; e++) begin
      if (ext_pol[e]) begin
        ext_evt[e] = ext_sync[e] & ~ext_last[e] & ext_warm[2];
      end else begin
        ext_evt[e] = ~ext_sync[e] & ext_last[e] & ext_warm[2];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      req_last <= '0;
    end else if (ce_i) begin
      req_last <= src_req_i;
    end
  end

  // A persistent source keeps setting its flag while it still requests,
  // so clearing the flag before servicing the source brings it back.
  always_comb begin
    hw_set = '0;
    for (int s = 0; s < NUM_SRC; s++) begin
      if (EXT_MASK[s]) begin
        hw_set[s] = 1'b0;
      end else if (PERSIST_MASK[s]) begin
        hw_set[s] = src_req_i[s];
      end else begin
        hw_set[s] = src_req_i[s] & ~req_last[s];
      end
    end
    for (int e = 0; e < NUM_EXT; e++) begin
      if (EXT_SRC[e] < NUM_SRC) begin
        hw_set[EXT_SRC[e]] = ext_evt[e];
      end
    end
  end

  // Write data lands first, then hardware events are ORed in, so an
  // event in the cycle of a clearing write is kept.
  always_comb begin
    next_flags = flags;
    if (wr_flag_lo) begin
      next_flags[31:0] = wdata_i;
    end
    if (wr_flag_hi) begin
      next_flags[63:32] = wdata_i;
    end
    next_flags = (next_flags | hw_set) & impl_mask;
  end

  always_comb begin
    next_enables = enables;
    if (wr_en_lo) begin
      next_enables[31:0] = wdata_i;
    end
    if (wr_en_hi) begin
      next_enables[63:32] = wdata_i;
    end
    next_enables = next_enables & impl_mask;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      flags <= '0;
    end else if (ce_i) begin
      flags <= next_flags;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      enables <= '0;
    end else if (ce_i) begin
      enables <= next_enables;
    end
  end

  // Each priority word keeps only its four five-bit slots.
  generate
    for (genvar r = 0; r < NUM_PRIO_REG; r++) begin : g_prio
      localparam logic [ADDR_W-1:0] OFF = ADDR_W'(OFF_PRIO_BASE + 4 * r);
      always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
          prio_reg[r] <= RST_WORD;
        end else if (ce_i && wr_i && addr_i == OFF) begin
          prio_reg[r] <= wdata_i & PRIO_MASK;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      multi_vec <= 1'b0;
      ext_pol   <= RST_POL;
    end else if (ce_i && wr_i && addr_i == OFF_CTRL) begin
      multi_vec <= wdata_i[CTRL_MVEC];
      ext_pol   <= wdata_i[CTRL_POL_LSB +: NUM_EXT];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      vbase <= RST_WORD;
    end else if (ce_i && wr_i && addr_i == OFF_VBASE) begin
      vbase <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      vspace <= RST_VSPACE;
    end else if (ce_i && wr_i && addr_i == OFF_VSPACE) begin
      vspace <= wdata_i[VSPACE_W-1:0];
    end
  end

  // Per vector: its fields and whether any enabled member is flagged.
  // The source table fixes which requests share each vector.
  generate
    for (genvar v = 0; v < NUM_VEC; v++) begin : g_vec
      localparam int REG  = v / 4;
      localparam int BASE = SLOT_W * (v % 4);
      assign vec_prio[v] = prio_reg[REG][BASE + PRIO_LSB +: 3];
      assign vec_sub[v]  = prio_reg[REG][BASE + SUB_LSB +: 2];
      always_comb begin
        vec_pend[v] = 1'b0;
        for (int s = 0; s < NUM_SRC; s++) begin
          if (int'(VEC_OF_SRC[s]) == v) begin
            vec_pend[v] = vec_pend[v] | (flags[s] & enables[s]);
          end
        end
      end
    end
  endgenerate

  // Scanning from the top vector down with a non-strict compare lets
  // the lowest vector win a tie. The chain is long but the core only
  // needs a fresh answer per cycle, not per request.
  always_comb begin
    win_found = 1'b0;
    win_vec   = '0;
    win_prio  = '0;
    win_sub   = '0;
    for (int v = NUM_VEC - 1; v >= 0; v--) begin
      if (vec_pend[v] && vec_prio[v] != 3'h0) begin
        if (!win_found || {vec_prio[v], vec_sub[v]} >= {win_prio, win_sub}) begin
          win_found = 1'b1;
          win_vec   = 6'(v);
          win_prio  = vec_prio[v];
          win_sub   = vec_sub[v];
        end
      end
    end
  end

  // Single-vector mode sends every request to the table base.
  always_comb begin
    if (multi_vec) begin
      next_addr = vbase + 32'(win_vec) * 32'(vspace);
    end else begin
      next_addr = vbase;
    end
  end

  // Only the winner leaves the block; no register-set select goes out.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      irq_o <= '0;
    end else if (ce_i) begin
      irq_o.valid  <= win_found;
      irq_o.vector <= win_vec;
      irq_o.prio   <= win_prio;
      irq_o.sub    <= win_sub;
      irq_o.addr   <= next_addr;
    end
  end

  always_comb begin
    next_rdata = '0;
    unique case (addr_i)
      OFF_FLAG_LO: begin
        next_rdata = flags[31:0];
      end
      OFF_FLAG_HI: begin
        next_rdata = flags[63:32];
      end
      OFF_EN_LO: begin
        next_rdata = enables[31:0];
      end
      OFF_EN_HI: begin
        next_rdata = enables[63:32];
      end
      OFF_CTRL: begin
        next_rdata[CTRL_MVEC] = multi_vec;
        next_rdata[CTRL_POL_LSB +: NUM_EXT] = ext_pol;
      end
      OFF_VBASE: begin
        next_rdata = vbase;
      end
      OFF_VSPACE: begin
        next_rdata[VSPACE_W-1:0] = vspace;
      end
      OFF_STATUS: begin
        next_rdata[31] = win_found;
        next_rdata[5:0] = win_vec;
      end
      default: begin
        for (int r = 0; r < NUM_PRIO_REG; r++) begin
          if (addr_i == ADDR_W'(OFF_PRIO_BASE + 4 * r)) begin
            next_rdata = prio_reg[r];
          end
        end
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else if (ce_i) begin
      if (rd_i) begin
        rdata_o <= next_rdata;
      end else begin
        rdata_o <= '0;
      end
    end
  end

endmodule // vic_top

// file: test/vic_assertions.sv
`timescale 1ns/100ps
module vic_assertions #(
  parameter int NUM_SRC = vic_pkg::SRC_MAX,
  parameter int NUM_VEC = vic_pkg::VEC_MAX
) (
  input wire logic                       mclk_i,
  input wire logic                       rst_n_i,
  input wire logic                       ce_i,
  input wire logic [vic_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0]                wdata_i,
  input wire logic                       wr_i,
  input wire logic                       rd_i,
  input wire logic [31:0]                rdata_o,
  input wire logic [NUM_SRC-1:0]         src_req_i,
  input wire logic [vic_pkg::NUM_EXT-1:0] ext_pin_i,
  input wire vic_pkg::vic_irq_t          irq_o
);
  import vic_pkg::*;
  // Shadows lag the registers by one cycle, which is exactly what the registered irq_o sees.
  logic        wr_d;
  logic [7:0]  a_d;
  logic [31:0] d_d;
  logic        mvec;
  logic [31:0] vbase;
  logic [15:0] vspace;
  logic [31:0] prio_reg [NUM_PRIO_REG];
  logic [4:0]  exp_ps;
  logic [31:0] exp_addr;
  always_ff @(posedge mclk_i) begin
    wr_d <= wr_i && ce_i && rst_n_i;
    a_d <= addr_i;
    d_d <= wdata_i;
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      mvec <= 1'b0;
      vbase <= '0;
      vspace <= RST_VSPACE;
      prio_reg <= '{default: '0};
    end else if (wr_d) begin
      if (a_d == OFF_CTRL) mvec <= d_d[CTRL_MVEC];
      if (a_d == OFF_VBASE) vbase <= d_d;
      if (a_d == OFF_VSPACE) vspace <= d_d[15:0];
      if (a_d >= OFF_PRIO_BASE && a_d <= 8'h30) prio_reg[(a_d - OFF_PRIO_BASE) >> 2] <= d_d;
    end
  end
  assign exp_ps = 5'(prio_reg[irq_o.vector[5:2]] >> {irq_o.vector[1:0], 3'h0});
  assign exp_addr = mvec ? vbase + 32'(irq_o.vector) * 32'(vspace) : vbase;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_read(logic [7:0] a);
    ce_i && rd_i && addr_i == a;
  endsequence
  AST_ZERO_PRIO: assert property (irq_o.valid |-> irq_o.prio != 3'h0)
    else $error("winner with priority zero");
  AST_FIELDS: assert property (irq_o.valid |-> {irq_o.prio, irq_o.sub} == exp_ps)
    else $error("winner fields differ from its slot");
  AST_ADDR: assert property (irq_o.valid |-> irq_o.addr == exp_addr)
    else $error("entry address wrong");
  AST_VEC_RANGE: assert property (irq_o.valid |-> irq_o.vector < 6'(NUM_VEC))
    else $error("vector out of range");
  AST_BASE_READ: assert property (s_read(OFF_VBASE) |=> rdata_o == vbase)
    else $error("base readback wrong");
  AST_SPACE_READ: assert property (s_read(OFF_VSPACE) |=> rdata_o[15:0] == vspace)
    else $error("spacing readback wrong");
  AST_RD_IDLE: assert property (ce_i && !rd_i |=> rdata_o == 32'h0)
    else $error("read data outside its cycle");
  AST_UNMAPPED: assert property (ce_i && rd_i && addr_i > OFF_STATUS |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  AST_FREEZE: assert property (!ce_i |=> $stable(irq_o))
    else $error("request moved while frozen");
endmodule // vic_assertions
bind vic_top vic_assertions #(.NUM_SRC(NUM_SRC), .NUM_VEC(NUM_VEC)) vic_assertions_i (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .src_req_i(src_req_i),
  .ext_pin_i(ext_pin_i), .irq_o(irq_o));

// file: test/vic_core_model.sv
`timescale 1ns/100ps
module vic_core_model (
  input  wire logic              mclk_i,
  input  wire vic_pkg::vic_irq_t irq_i,
  output vic_pkg::vic_irq_t      seen_o,
  output logic                   taken_o
);
  import vic_pkg::*;
  // The core has no acknowledge path, so it only notes each newly presented vector.
  vic_irq_t last = '0;
  always_ff @(posedge mclk_i) begin
    last <= irq_i;
    seen_o <= irq_i;
    taken_o <= irq_i.valid && (!last.valid || irq_i.vector != last.vector);
  end
endmodule // vic_core_model

// file: test/test_vectored_interrupt_controller.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module test_vectored_interrupt_controller;
  import vic_pkg::*;
  logic        mclk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic        rd_d = 1'b0, taken;
  logic [7:0]  addr_i = '0, fl;
  logic [31:0] wdata_i = '0, rdata_o, vb, exp_rd;
  logic [43:0] src_req_i = '0;
  logic [4:0]  ext_pin_i = '0;
  logic [15:0] vs;
  logic [2:0]  p;
  logic [1:0]  sb;
  vic_irq_t    irq_o, seen, exp_irq;
  logic [31:0] rdq[$];
  vic_irq_t    iq[$];
  int          mismatches = 0, n_tests = 0, seed = 59610, s, v;
  int src_t[18] = '{0, 1, 2, 4, 5, 6, 7, 27, 28, 29, 30, 31, 32, 33, 34, 35, 38, 43};
  int vec_t[18] = '{0, 1, 2, 4, 5, 5, 6, 22, 23, 24, 25, 26, 27, 28, 29, 30, 31, 32};
  logic [17:0] per_t = 18'h3C130;
  vic_top vic_top_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .src_req_i(src_req_i),
    .ext_pin_i(ext_pin_i), .irq_o(irq_o));
  vic_core_model vic_core_model_i (.mclk_i(mclk_i), .irq_i(irq_o), .seen_o(seen),
    .taken_o(taken));
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    rd_d <= rd_i;
    // The macro names its expected value twice, so each note is popped first.
    if (rd_d) begin
      exp_rd = (rdq.size() > 0) ? rdq.pop_front() : 32'hDEAD_BEEF;
      `CHK("rdata", exp_rd, rdata_o)
    end
    if (taken === 1'b1) begin
      exp_irq = (iq.size() > 0) ? iq.pop_front() : '0;
      `CHK("irq", exp_irq, seen)
    end
  end
  function automatic vic_irq_t mk(int v, int p, int sb, logic [31:0] a);
    return vic_irq_t'({1'b1, 6'(v), 3'(p), 2'(sb), a});
  endfunction
  task automatic cyc(int n = 1);
    repeat (n) @(posedge mclk_i);
  endtask
  // Each access leaves one idle cycle so a strobe is never driven twice in one step.
  task automatic wr(logic [7:0] a, logic [31:0] d);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    cyc();
    wr_i <= 1'b0;
    cyc();
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    rdq.push_back(e);
    rd_i <= 1'b1;
    addr_i <= a;
    cyc();
    rd_i <= 1'b0;
    cyc();
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic drain(string nm);
    int i;
    for (i = 0; i < 40 && iq.size() + rdq.size() > 0; i++) cyc();
    if (i == 40) begin
      mismatches++;
      test_done();
    end
    $display("end of %s", nm);
  endtask
  initial begin
    cyc(20);
    rst_n_i <= 1'b1;
    cyc();
    rd(OFF_EN_LO, 32'h0);
    rd(OFF_CTRL, 32'h1F00);
    wr(8'h50, 32'hFFFF_FFFF);
    rd(8'h50, 32'h0);
    wr(OFF_PRIO_BASE, 32'hFFFF_FFFF);
    rd(OFF_PRIO_BASE, 32'h1F1F_1F1F);
    drain("registers");
    vb = $random(seed);
    vs = 16'($random(seed));
    wr(OFF_CTRL, 32'h1F01);
    wr(OFF_VBASE, vb);
    wr(OFF_VSPACE, {16'h0, vs});
    foreach (src_t[i]) begin
      s = src_t[i];
      v = vec_t[i];
      p = 3'($random(seed));
      sb = 2'($random(seed));
      if (p == 3'h0) p = 3'h7;
      fl = (s < 32) ? OFF_FLAG_LO : OFF_FLAG_HI;
      wr(OFF_PRIO_BASE + 8'(4 * (v / 4)), 32'({p, sb}) << (8 * (v % 4)));
      wr(fl + 8'h08, 32'h1 << (s % 32));
      iq.push_back(mk(v, p, sb, vb + 32'(v) * 32'(vs)));
      src_req_i[s] <= 1'b1;
      drain("mapping");
      wr(fl, 32'h0);
      rd(fl, 32'(per_t[i]) << (s % 32));
      src_req_i[s] <= 1'b0;
      wr(fl, 32'h0);
      wr(fl + 8'h08, 32'h0);
    end
    wr(OFF_CTRL, 32'h1F00);
    wr(OFF_EN_LO, 32'h210);
    wr(OFF_PRIO_BASE + 8'h04, 32'h16);
    wr(OFF_PRIO_BASE + 8'h08, 32'h16);
    iq.push_back(mk(4, 5, 2, vb));
    wr(OFF_FLAG_LO, 32'h210);
    drain("tie");
    rd(OFF_STATUS, 32'h8000_0004);
    iq.push_back(mk(8, 5, 2, vb));
    wr(OFF_PRIO_BASE + 8'h04, 32'h02);
    drain("disable");
    iq.push_back(mk(4, 5, 3, vb));
    wr(OFF_PRIO_BASE + 8'h04, 32'h17);
    drain("subpriority");
    wr(OFF_FLAG_LO, 32'h0);
    // Pins 0, 2 and 4 start low and rise; pins 1 and 3 start high and fall.
    wr(OFF_CTRL, 32'h1501);
    ext_pin_i <= 5'h0A;
    cyc(6);
    for (int k = 0; k < 5; k++) begin
      s = 5 * k + 3;
      v = 4 * k + 3;
      wr(OFF_FLAG_LO, 32'h0);
      wr(OFF_PRIO_BASE + 8'(4 * (v / 4)), 32'h1D << (8 * (v % 4)));
      wr(OFF_EN_LO, 32'h1 << s);
      iq.push_back(mk(v, 7, 1, vb + 32'(v) * 32'(vs)));
      ext_pin_i[k] <= ~ext_pin_i[k];
      drain("external");
      wr(OFF_EN_LO, 32'h0);
    end
    ce_i <= 1'b0;
    cyc(3);
    ce_i <= 1'b1;
    rst_n_i <= 1'b0;
    cyc(2);
    rst_n_i <= 1'b1;
    cyc();
    rd(OFF_VSPACE, 32'h20);
    rd(OFF_FLAG_LO, 32'h0);
    drain("reset");
    test_done();
  end
endmodule // test_vectored_interrupt_controller
